// ==== blkrp_regs.svh ====
// register offsets, field positions, codes and reset values of the block request processor
`ifndef BLKRP_REGS_SVH
`define BLKRP_REGS_SVH
`define BLKRP_A_FEAT 8'h00
`define BLKRP_A_WBACK 8'h04
`define BLKRP_A_CAPLO 8'h08
`define BLKRP_A_CAPHI 8'h0C
`define BLKRP_A_SEGMAX 8'h10
`define BLKRP_A_UNMAP 8'h14
`define BLKRP_A_STAT 8'h18
`define BLKRP_F_RO 0
`define BLKRP_F_FLUSH_OFF 1
`define BLKRP_F_FLUSH_NEG 2
`define BLKRP_F_WCE_NEG 3
`define BLKRP_F_BARRIER 4
`define BLKRP_F_SCSI 5
`define BLKRP_F_LEGACY 6
`define BLKRP_F_GUEST_BE 7
`define BLKRP_F_PERSIST 8
`define BLKRP_FEAT_W 9
`define BLKRP_FEAT_RST 9'h102
`define BLKRP_WBACK_RST 1'b0
`define BLKRP_UNMAP_RST 1'b1
`define BLKRP_SEGMAX_RST 32'h00010001
`define BLKRP_T_IN 32'h00000000
`define BLKRP_T_OUT 32'h00000001
`define BLKRP_T_SCSI 32'h00000002
`define BLKRP_T_SCSI_OUT 32'h00000003
`define BLKRP_T_FLUSH 32'h00000004
`define BLKRP_T_FLUSH_OUT 32'h00000005
`define BLKRP_T_DISCARD 32'h0000000B
`define BLKRP_T_WZ 32'h0000000D
`define BLKRP_T_BARRIER_BIT 31
`define BLKRP_S_OK 8'h00
`define BLKRP_S_IOERR 8'h01
`define BLKRP_S_UNSUPP 8'h02
`define BLKRP_SECT_MASK 32'h000001FF
`define BLKRP_SENSE_SIZE 32'h00000060
`define BLKRP_SEG_UNMAP 0
`endif

// ==== blkrp_pkg.sv ====
// types of the block request processor
`default_nettype none
package blkrp_pkg;
	typedef enum logic [2:0] {
		BLKRP_OP_READ = 3'b000,
		BLKRP_OP_WRITE = 3'b001,
		BLKRP_OP_FLUSH = 3'b010,
		BLKRP_OP_DISCARD = 3'b011,
		BLKRP_OP_WZ = 3'b100,
		BLKRP_OP_SCSI = 3'b101,
		BLKRP_OP_BAD = 3'b111
	} blkrp_op_t;
	typedef enum logic [2:0] {
		BLKRP_ST_IDLE = 3'b000,
		BLKRP_ST_CHECK = 3'b001,
		BLKRP_ST_SEG = 3'b010,
		BLKRP_ST_ISSUE = 3'b011,
		BLKRP_ST_WAIT = 3'b100,
		BLKRP_ST_DONE = 3'b101
	} blkrp_state_t;
endpackage
`default_nettype wire

// ==== blkrp_dec_if.sv ====
// raw request header in, decoded request out
`default_nettype none
interface blkrp_dec_if;
	import blkrp_pkg::*;
	logic [31:0] raw_type;
	logic [63:0] raw_sector;
	logic swap;
	blkrp_op_t op;
	logic barrier;
	logic [63:0] sector;
	modport dec (input raw_type, raw_sector, swap, output op, barrier, sector);
	modport core (output raw_type, raw_sector, swap, input op, barrier, sector);
endinterface
`default_nettype wire

// ==== blkrp_decode.sv ====
// byte order correction and type classification of a request header
`default_nettype none
`include "blkrp_regs.svh"
module blkrp_decode
	import blkrp_pkg::*;
(
	blkrp_dec_if.dec d,
	input wire logic scsi_en
);
	logic [31:0] t;

	function automatic logic [31:0] swap32(input logic [31:0] v);
		swap32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
	endfunction

	// legacy guests use native order, so swap only for a big-endian legacy guest
	assign t = d.swap ? swap32(d.raw_type) : d.raw_type;
	assign d.sector = d.swap ? {swap32(d.raw_sector[31:0]), swap32(d.raw_sector[63:32])}
		: d.raw_sector;
	assign d.barrier = t[`BLKRP_T_BARRIER_BIT];

	always_comb begin
		case ({1'b0, t[30:0]})
			`BLKRP_T_IN: d.op = BLKRP_OP_READ;
			`BLKRP_T_OUT: d.op = BLKRP_OP_WRITE;
			`BLKRP_T_FLUSH, `BLKRP_T_FLUSH_OUT: d.op = BLKRP_OP_FLUSH;
			`BLKRP_T_DISCARD: d.op = BLKRP_OP_DISCARD;
			`BLKRP_T_WZ: d.op = BLKRP_OP_WZ;
			`BLKRP_T_SCSI, `BLKRP_T_SCSI_OUT: d.op = scsi_en ? BLKRP_OP_SCSI : BLKRP_OP_BAD;
			default: d.op = BLKRP_OP_BAD;
		endcase
	end
endmodule
`default_nettype wire

// ==== blkrp_stable.sv ====
// decides whether a write must be committed before completion, tracks volatile data
`default_nettype none
`include "blkrp_regs.svh"
module blkrp_stable #(
	parameter bit COMMIT_NOFLUSH = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`BLKRP_FEAT_W-1:0] feat,
	input wire logic writeback,
	input wire logic wb_write,
	input wire logic write_start,
	input wire logic write_done,
	input wire logic flush_done,
	output logic commit_write,
	output logic volatile_pend
);
	logic wb_touched;
	logic case1;
	logic case2;

	// any writeback update while a write is in flight voids the writethrough guarantee;
	// cleared when the write is submitted, and a touch in that same cycle still counts
	always_ff @(posedge clk) begin
		if (!rst_n)
			wb_touched <= 1'b0;
		else if (wb_write)
			wb_touched <= 1'b1;
		else if (write_start)
			wb_touched <= 1'b0;
	end

	assign case1 = feat[`BLKRP_F_FLUSH_OFF] && !feat[`BLKRP_F_FLUSH_NEG]
		&& !feat[`BLKRP_F_WCE_NEG];
	assign case2 = feat[`BLKRP_F_WCE_NEG] && !writeback && !wb_touched && !wb_write;
	assign commit_write = feat[`BLKRP_F_PERSIST] && (case1 || case2
		|| (!feat[`BLKRP_F_FLUSH_OFF] && COMMIT_NOFLUSH));

	// set wins over the clear by a flush
	always_ff @(posedge clk) begin
		if (!rst_n)
			volatile_pend <= 1'b0;
		else if (write_done && !commit_write)
			volatile_pend <= 1'b1;
		else if (flush_done)
			volatile_pend <= 1'b0;
	end
endmodule
`default_nettype wire

// ==== blkrp_top.sv ====
// block request processor: checks requests, drives storage, returns status
// Operation
// - writeback field selects writethrough (0) or writeback (1); device follows it.
// - read-only device fails every write with I/O error, storage untouched; the code fails only type 1, write-zeroes and discard still reach storage.
// - unknown segment flags, or unmap on discard, give unsupported status.
// - write-zeroes makes covered sectors read zero; unmap may deallocate them.
// - discard may deallocate the listed ranges.
// - may-unmap field tracks deallocation ability; a change raises config notification.
// - a write is stable in case 1, writethrough case 2, or after flush.
// - persistent storage commits stable data before the write or flush completes.
// - without flush offered, committing writes before completion is optional.
// - legacy header and trailer fields use guest native byte order.
// - legacy type 5 behaves exactly as flush.
// - barrier bit waits for earlier requests and holds later ones back.
// - with SCSI feature, types 2 and 3 are the same packet command.
// - sense length reports sense bytes written into the 96-byte buffer.
// - residual equals requested length minus bytes actually transferred.
// - status byte is 0 ok, 1 I/O error, 2 unsupported.
// - type codes are 0 read, 1 write, 4 flush, 11 discard, 13 write-zeroes.
//
// The address map and register access over Wishbone were left to the implementer.
`default_nettype none
`include "blkrp_regs.svh"
module blkrp_top
	import blkrp_pkg::*;
#(
	parameter bit COMMIT_NOFLUSH = 1'b0
) (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic [31:0] REQ_TYPE,
	input wire logic [63:0] REQ_SECTOR,
	input wire logic [31:0] REQ_LEN,
	input wire logic [31:0] REQ_NSEG,
	input wire logic SEG_VALID,
	output logic SEG_READY,
	input wire logic [63:0] SEG_SECTOR,
	input wire logic [31:0] SEG_NUM,
	input wire logic [31:0] SEG_FLAGS,
	output logic STO_VALID,
	output logic [2:0] STO_OP,
	output logic [63:0] STO_SECTOR,
	output logic [31:0] STO_LEN,
	output logic STO_COMMIT,
	output logic STO_UNMAP,
	input wire logic STO_DONE,
	input wire logic STO_ERR,
	input wire logic [31:0] STO_XFER,
	input wire logic [31:0] STO_SENSE_LEN,
	output logic CPL_VALID,
	output logic [7:0] CPL_STATUS,
	output logic [31:0] CPL_SENSE_LEN,
	output logic [31:0] CPL_RESIDUAL,
	output logic CFG_CHANGE
);
	blkrp_state_t state;
	blkrp_op_t op;
	logic [`BLKRP_FEAT_W-1:0] feat;
	logic writeback;
	logic may_unmap;
	logic [63:0] capacity;
	logic [31:0] segmax;
	logic [31:0] len;
	logic [31:0] nseg;
	logic [31:0] segs_left;
	logic [63:0] sector;
	logic [7:0] status;
	logic commit_write;
	logic volatile_pend;
	logic wb_hit;
	logic wb_wr;
	logic [31:0] rd_data;
	logic [31:0] wmask;
	logic seg_take;
	logic seg_bad;

	blkrp_dec_if dif ();

	function automatic logic [31:0] swap32(input logic [31:0] v);
		swap32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m);
		merge = (old & ~m) | (WB_DAT_I & m);
	endfunction

	// ------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------
	assign wb_hit = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign wb_wr = wb_hit && WB_WE_I;
	assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N)
			WB_ACK_O <= 1'b0;
		else
			WB_ACK_O <= wb_hit;
	end

	always_comb begin
		case (WB_ADR_I)
			`BLKRP_A_FEAT: rd_data = {23'h000000, feat};
			`BLKRP_A_WBACK: rd_data = {31'h00000000, writeback};
			`BLKRP_A_CAPLO: rd_data = capacity[31:0];
			`BLKRP_A_CAPHI: rd_data = capacity[63:32];
			`BLKRP_A_SEGMAX: rd_data = segmax;
			`BLKRP_A_UNMAP: rd_data = {31'h00000000, may_unmap};
			`BLKRP_A_STAT: rd_data = {26'h0000000, volatile_pend, state, REQ_READY, CPL_VALID};
			default: rd_data = 32'h00000000;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N)
			WB_DAT_O <= 32'h00000000;
		else if (wb_hit && !WB_WE_I)
			WB_DAT_O <= rd_data;
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			feat <= `BLKRP_FEAT_RST;
			capacity <= 64'h0000000000000000;
			segmax <= `BLKRP_SEGMAX_RST;
		end else if (wb_wr) begin
			if (WB_ADR_I == `BLKRP_A_FEAT)
				feat <= `BLKRP_FEAT_W'(merge({23'h000000, feat}, wmask));
			if (WB_ADR_I == `BLKRP_A_CAPLO)
				capacity[31:0] <= merge(capacity[31:0], wmask);
			if (WB_ADR_I == `BLKRP_A_CAPHI)
				capacity[63:32] <= merge(capacity[63:32], wmask);
			if (WB_ADR_I == `BLKRP_A_SEGMAX)
				segmax <= merge(segmax, wmask);
		end
	end

	// cache mode takes effect on the next write request
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N)
			writeback <= `BLKRP_WBACK_RST;
		else if (wb_wr && WB_ADR_I == `BLKRP_A_WBACK && WB_SEL_I[0] && feat[`BLKRP_F_WCE_NEG])
			writeback <= WB_DAT_I[0];
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			may_unmap <= `BLKRP_UNMAP_RST;
			CFG_CHANGE <= 1'b0;
		end else begin
			CFG_CHANGE <= 1'b0;
			if (wb_wr && WB_ADR_I == `BLKRP_A_UNMAP && WB_SEL_I[0]) begin
				may_unmap <= WB_DAT_I[0];
				CFG_CHANGE <= WB_DAT_I[0] != may_unmap;
			end
		end
	end

	// ------------------------------------------------------------
	// header decode and stability
	// ------------------------------------------------------------
	assign dif.raw_type = REQ_TYPE;
	assign dif.raw_sector = REQ_SECTOR;
	assign dif.swap = feat[`BLKRP_F_LEGACY] && feat[`BLKRP_F_GUEST_BE];

	blkrp_decode u_dec (
		.d(dif),
		.scsi_en(feat[`BLKRP_F_SCSI])
	);

	blkrp_stable #(.COMMIT_NOFLUSH(COMMIT_NOFLUSH)) u_stab (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.feat(feat),
		.writeback(writeback),
		.wb_write(wb_wr && WB_ADR_I == `BLKRP_A_WBACK),
		.write_start(state == BLKRP_ST_IDLE && REQ_VALID && REQ_READY
			&& dif.op == BLKRP_OP_WRITE),
		.write_done(state == BLKRP_ST_WAIT && STO_DONE && op == BLKRP_OP_WRITE),
		.flush_done(state == BLKRP_ST_WAIT && STO_DONE && op == BLKRP_OP_FLUSH),
		.commit_write(commit_write),
		.volatile_pend(volatile_pend)
	);

	// ------------------------------------------------------------
	// request sequencer
	// ------------------------------------------------------------
	// one request at a time, so a barrier always finds earlier work done
	// and later work held off; caches are not flushed by it
	assign seg_take = SEG_VALID && SEG_READY;
	assign seg_bad = (|SEG_FLAGS[31:1])
		|| (op == BLKRP_OP_DISCARD && SEG_FLAGS[`BLKRP_SEG_UNMAP]);

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			state <= BLKRP_ST_IDLE;
			op <= BLKRP_OP_BAD;
			REQ_READY <= 1'b0;
			SEG_READY <= 1'b0;
			STO_VALID <= 1'b0;
			STO_OP <= 3'h0;
			STO_SECTOR <= 64'h0000000000000000;
			STO_LEN <= 32'h00000000;
			STO_COMMIT <= 1'b0;
			STO_UNMAP <= 1'b0;
			CPL_VALID <= 1'b0;
			CPL_STATUS <= `BLKRP_S_OK;
			CPL_SENSE_LEN <= 32'h00000000;
			CPL_RESIDUAL <= 32'h00000000;
			len <= 32'h00000000;
			nseg <= 32'h00000000;
			segs_left <= 32'h00000000;
			sector <= 64'h0000000000000000;
			status <= `BLKRP_S_OK;
		end else begin
			STO_VALID <= 1'b0;
			CPL_VALID <= 1'b0;
			case (state)
				BLKRP_ST_IDLE: begin
					REQ_READY <= 1'b1;
					if (REQ_VALID && REQ_READY) begin
						REQ_READY <= 1'b0;
						op <= dif.op;
						sector <= dif.sector;
						len <= dif.swap ? swap32(REQ_LEN) : REQ_LEN;
						nseg <= dif.swap ? swap32(REQ_NSEG) : REQ_NSEG;
						status <= `BLKRP_S_OK;
						CPL_SENSE_LEN <= 32'h00000000;
						CPL_RESIDUAL <= 32'h00000000;
						state <= BLKRP_ST_CHECK;
					end
				end
				BLKRP_ST_CHECK: begin
					segs_left <= nseg;
					state <= BLKRP_ST_ISSUE;
					case (op)
						BLKRP_OP_BAD: begin
							status <= `BLKRP_S_UNSUPP;
							state <= BLKRP_ST_DONE;
						end
						BLKRP_OP_WRITE: if (feat[`BLKRP_F_RO]) begin
							status <= `BLKRP_S_IOERR;
							state <= BLKRP_ST_DONE;
						end else if ((len & `BLKRP_SECT_MASK) != 32'h00000000
								|| sector + {41'h0, len[31:9]} > capacity) begin
							status <= `BLKRP_S_IOERR;
							state <= BLKRP_ST_DONE;
						end
						BLKRP_OP_READ: if ((len & `BLKRP_SECT_MASK) != 32'h00000000
								|| sector + {41'h0, len[31:9]} > capacity) begin
							status <= `BLKRP_S_IOERR;
							state <= BLKRP_ST_DONE;
						end
						BLKRP_OP_DISCARD, BLKRP_OP_WZ: begin
							if (nseg == 32'h00000000 || nseg > {16'h0000, (op == BLKRP_OP_WZ)
									? segmax[31:16] : segmax[15:0]}) begin
								status <= `BLKRP_S_IOERR;
								state <= BLKRP_ST_DONE;
							end else begin
								SEG_READY <= 1'b1;
								state <= BLKRP_ST_SEG;
							end
						end
						default: ;
					endcase
				end
				BLKRP_ST_SEG: if (seg_take) begin
					SEG_READY <= 1'b0;
					segs_left <= segs_left - 32'h00000001;
					if (seg_bad || status != `BLKRP_S_OK) begin
						// stop issuing, keep draining the remaining segments
						status <= (status == `BLKRP_S_OK) ? `BLKRP_S_UNSUPP : status;
						SEG_READY <= segs_left != 32'h00000001;
						state <= (segs_left == 32'h00000001) ? BLKRP_ST_DONE : BLKRP_ST_SEG;
					end else begin
						STO_VALID <= 1'b1;
						STO_OP <= op;
						STO_SECTOR <= SEG_SECTOR;
						STO_LEN <= SEG_NUM;
						STO_UNMAP <= (op == BLKRP_OP_WZ) && SEG_FLAGS[`BLKRP_SEG_UNMAP]
							&& may_unmap;
						STO_COMMIT <= 1'b0;
						state <= BLKRP_ST_WAIT;
					end
				end
				BLKRP_ST_ISSUE: begin
					STO_VALID <= 1'b1;
					STO_OP <= op;
					STO_SECTOR <= sector;
					STO_LEN <= len;
					STO_UNMAP <= 1'b0;
					STO_COMMIT <= (op == BLKRP_OP_WRITE && commit_write)
						|| (op == BLKRP_OP_FLUSH && feat[`BLKRP_F_PERSIST]);
					state <= BLKRP_ST_WAIT;
				end
				BLKRP_ST_WAIT: if (STO_DONE) begin
					if (STO_ERR)
						status <= `BLKRP_S_IOERR;
					if (op == BLKRP_OP_SCSI) begin
						CPL_SENSE_LEN <= (STO_SENSE_LEN > `BLKRP_SENSE_SIZE) ? `BLKRP_SENSE_SIZE
							: STO_SENSE_LEN;
						CPL_RESIDUAL <= len - STO_XFER;
					end
					if ((op == BLKRP_OP_DISCARD || op == BLKRP_OP_WZ) && segs_left != 32'h0) begin
						SEG_READY <= 1'b1;
						state <= BLKRP_ST_SEG;
					end else
						state <= BLKRP_ST_DONE;
				end
				BLKRP_ST_DONE: begin
					// status only after all storage traffic of the request is over
					CPL_VALID <= 1'b1;
					CPL_STATUS <= status;
					CPL_SENSE_LEN <= dif.swap ? swap32(CPL_SENSE_LEN) : CPL_SENSE_LEN;
					CPL_RESIDUAL <= dif.swap ? swap32(CPL_RESIDUAL) : CPL_RESIDUAL;
					state <= BLKRP_ST_IDLE;
				end
				default: state <= BLKRP_ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	sequence s_write_taken;
		state == BLKRP_ST_CHECK && op == BLKRP_OP_WRITE && feat[`BLKRP_F_RO];
	endsequence

	a_ro_write_err: assert property (s_write_taken |-> ##2 CPL_VALID
		&& CPL_STATUS == `BLKRP_S_IOERR)
		else $error("read-only write not failed");
	a_ro_no_store: assert property (s_write_taken |-> ##1 !STO_VALID [*2])
		else $error("read-only write reached storage");
	a_seg_unsupp: assert property (seg_take && seg_bad |=> status == `BLKRP_S_UNSUPP)
		else $error("bad segment flags not unsupported");
	a_cpl_after_done: assert property (CPL_VALID |-> $past(state) == BLKRP_ST_DONE)
		else $error("completion without finished transfer");
	a_cpl_status_code: assert property (CPL_VALID |-> CPL_STATUS <= `BLKRP_S_UNSUPP)
		else $error("illegal status byte");
	a_sense_bound: assert property (CPL_VALID && !dif.swap
		|-> CPL_SENSE_LEN <= `BLKRP_SENSE_SIZE)
		else $error("sense length above buffer");
	a_one_request: assert property (REQ_VALID && REQ_READY |=> !REQ_READY [*3])
		else $error("request taken while busy");
	a_unmap_notify: assert property ($changed(may_unmap) |-> CFG_CHANGE)
		else $error("may-unmap change without notification");
	a_wb_follow: assert property (wb_wr && WB_ADR_I == `BLKRP_A_WBACK && WB_SEL_I[0]
		&& feat[`BLKRP_F_WCE_NEG] |=> writeback == $past(WB_DAT_I[0]))
		else $error("writeback mode not adopted");
	a_flush_commit: assert property (STO_VALID && STO_OP == BLKRP_OP_FLUSH
		&& feat[`BLKRP_F_PERSIST] |-> STO_COMMIT)
		else $error("flush without commit");
endmodule
`default_nettype wire

// ==== blkrp_sto_model.sv ====
// storage back end model answering the request processor's commands
`default_nettype none
module blkrp_sto_model #(
	parameter logic [31:0] SENSE_BYTES = 32'h00000012
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sto_valid,
	input wire logic [31:0] sto_len,
	input wire logic [31:0] short_by,
	input wire logic slow,
	output logic sto_done,
	output logic sto_err,
	output logic [31:0] sto_xfer,
	output logic [31:0] sto_sense
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy;
	logic [31:0] wait_n;
	logic [31:0] len_q;
	always @(posedge clk) begin
		sto_done <= 1'b0;
		sto_err <= 1'b0;
		// stale result lines flip so nobody reads them outside done
		sto_xfer <= ~sto_xfer;
		sto_sense <= ~sto_sense;
		if (!rst_n) begin
			busy <= 1'b0;
			sto_xfer <= 32'h0;
			sto_sense <= 32'h0;
		end else if (sto_valid) begin
			busy <= 1'b1;
			wait_n <= slow ? 32'($urandom % 6) : 32'h0;
			len_q <= sto_len;
		end else if (busy && wait_n == 0) begin
			busy <= 1'b0;
			sto_done <= 1'b1;
			sto_xfer <= len_q - short_by;
			sto_sense <= SENSE_BYTES;
		end else if (busy) begin
			wait_n <= wait_n - 1;
		end
	end
endmodule
`default_nettype wire

// ==== tb_block_request_processor.sv ====
// self-checking bench of the block request processor
`default_nettype none
`include "blkrp_regs.svh"
module tb_block_request_processor
	import blkrp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, cyc, stb, we, ack, rv, rr, sv, sr, stv, com, unm, dn, er, cv, cfg, slow;
	logic [7:0] adr, sts;
	logic [3:0] sel;
	logic [2:0] op, op_q;
	logic [31:0] wd, rd, rt, rl, rn, sn, sf, sl, sx, ss, cs, cr, q, short_by, seed_v;
	logic [63:0] rs, ssec, stsec;
	logic com_q, unm_q, cfg_seen;
	int sto_n, miscompares, tests_run, cycles;
	blkrp_top blkrp_top_inst (.CLK_SYS(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rd),
		.WB_ACK_O(ack), .REQ_VALID(rv), .REQ_READY(rr), .REQ_TYPE(rt), .REQ_SECTOR(rs),
		.REQ_LEN(rl), .REQ_NSEG(rn), .SEG_VALID(sv), .SEG_READY(sr), .SEG_SECTOR(ssec),
		.SEG_NUM(sn), .SEG_FLAGS(sf), .STO_VALID(stv), .STO_OP(op), .STO_SECTOR(stsec),
		.STO_LEN(sl), .STO_COMMIT(com), .STO_UNMAP(unm), .STO_DONE(dn), .STO_ERR(er),
		.STO_XFER(sx), .STO_SENSE_LEN(ss), .CPL_VALID(cv), .CPL_STATUS(sts),
		.CPL_SENSE_LEN(cs), .CPL_RESIDUAL(cr), .CFG_CHANGE(cfg));
	blkrp_sto_model blkrp_sto_model_inst (.clk(clk), .rst_n(rst_n), .sto_valid(stv),
		.sto_len(sl), .short_by(short_by), .slow(slow), .sto_done(dn), .sto_err(er),
		.sto_xfer(sx), .sto_sense(ss));
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (stv === 1'b1) begin
			sto_n++;
			op_q = op;
			com_q = com;
			unm_q = unm;
		end
		if (cfg === 1'b1)
			cfg_seen = 1'b1;
		if (cycles == 20000) begin
			miscompares++;
			test_done();
		end
	end
	// ----------------------------------------
	// comparison and bus tasks
	// ----------------------------------------
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask
	task automatic chk_sts(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("CHECK FAILED %0t status %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// header first, then segments, completion status last
	// segments before the last carry zero flags, the last one carries flg
	task automatic req(input logic [31:0] t, input logic [63:0] s, input logic [31:0] l,
		input logic [31:0] n, input int send, input logic [31:0] flg);
		sto_n = 0;
		@(posedge clk);
		rv <= 1'b1;
		rt <= t;
		rs <= s;
		rl <= l;
		rn <= n;
		do @(posedge clk); while (rr !== 1'b1);
		rv <= 1'b0;
		for (int i = 0; i < send; i++) begin
			sv <= 1'b1;
			ssec <= 64'($urandom % 256);
			sn <= 32'(1 + $urandom % 8);
			sf <= (i == send - 1) ? flg : 32'h0;
			do @(posedge clk); while (sr !== 1'b1);
		end
		sv <= 1'b0;
		do @(posedge clk); while (cv !== 1'b1);
	endtask
	task automatic exp_req(input logic [7:0] s, input int n, input logic [2:0] o);
		chk_sts(sts, s);
		chk_reg(32'(sto_n), 32'(n));
		if (n > 0)
			chk_reg(32'(op_q), 32'(o));
	endtask
	task automatic test_done();
		if (miscompares == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] types[4] = '{32'h0, 32'h1, 32'h4, 32'h5};
		logic [2:0] ops[4] = '{3'h0, 3'h1, 3'h2, 3'h2};
		logic [31:0] len;
		{clk, rst_n, cyc, stb, we, rv, sv, slow, cfg_seen} = '0;
		{adr, wd, rt, rs, rl, rn, ssec, sn, sf, short_by} = '0;
		sel = 4'hF;
		sto_n = 0;
		cycles = 0;
		miscompares = 0;
		tests_run = 0;
		seed_v = $urandom(27183);
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		wb(1'b0, 8'h00, 32'h0); chk_reg(q, 32'h00000102);
		wb(1'b0, 8'h10, 32'h0); chk_reg(q, 32'h00010001);
		wb(1'b0, 8'h14, 32'h0); chk_reg(q, 32'h00000001);
		wb(1'b0, 8'h40, 32'h0); chk_reg(q, 32'h00000000);
		wb(1'b1, 8'h04, 32'h1); wb(1'b0, 8'h04, 32'h0); chk_reg(q, 32'h0);
		wb(1'b1, 8'h08, 32'h00001000);
		for (int r = 0; r < 8; r++) begin
			len = 32'((1 + $urandom % 8) * 512);
			slow <= r[0];
			req(types[r % 4], (r % 4 > 1) ? 64'h0 : 64'($urandom % 3840),
				(r % 4 > 1) ? 32'h0 : len, 32'h0, 0, 32'h0);
			exp_req(8'h00, 1, ops[r % 4]);
			if (r % 4 == 1)
				chk_reg(32'(com_q), 32'h1);
		end
		req(32'h0, 64'h10, 32'd1000, 32'h0, 0, 32'h0); exp_req(8'h01, 0, 3'h0);
		req(32'h0, 64'hFFF, 32'd1024, 32'h0, 0, 32'h0); exp_req(8'h01, 0, 3'h0);
		req(32'h7, 64'h0, 32'h0, 32'h0, 0, 32'h0); exp_req(8'h02, 0, 3'h0);
		req(32'hB, 64'h0, 32'd16, 32'h1, 1, 32'h0); exp_req(8'h00, 1, 3'h3);
		req(32'hB, 64'h0, 32'd16, 32'h1, 1, 32'h1); exp_req(8'h02, 0, 3'h0);
		req(32'hD, 64'h0, 32'd16, 32'h1, 1, 32'h2); exp_req(8'h02, 0, 3'h0);
		req(32'hD, 64'h0, 32'd16, 32'h1, 1, 32'h1); exp_req(8'h00, 1, 3'h4);
		chk_reg(32'(unm_q), 32'h1);
		wb(1'b1, 8'h10, 32'h00020002);
		req(32'hB, 64'h0, 32'd32, 32'h2, 2, 32'h4); exp_req(8'h02, 1, 3'h3);
		req(32'hD, 64'h0, 32'd48, 32'h3, 0, 32'h0); exp_req(8'h01, 0, 3'h0);
		wb(1'b1, 8'h00, 32'h10E);
		wb(1'b1, 8'h04, 32'h1); wb(1'b0, 8'h04, 32'h0); chk_reg(q, 32'h1);
		req(32'h1, 64'h20, 32'd512, 32'h0, 0, 32'h0); exp_req(8'h00, 1, 3'h1);
		chk_reg(32'(com_q), 32'h0);
		req(32'h4, 64'h0, 32'h0, 32'h0, 0, 32'h0); exp_req(8'h00, 1, 3'h2);
		chk_reg(32'(com_q), 32'h1);
		wb(1'b1, 8'h04, 32'h0);
		req(32'h1, 64'h20, 32'd512, 32'h0, 0, 32'h0); exp_req(8'h00, 1, 3'h1);
		chk_reg(32'(com_q), 32'h1);
		wb(1'b1, 8'h00, 32'h103);
		req(32'h1, 64'h20, 32'd512, 32'h0, 0, 32'h0); exp_req(8'h01, 0, 3'h0);
		wb(1'b1, 8'h00, 32'h122);
		for (int r = 2; r < 4; r++) begin
			len = 32'((1 + $urandom % 4) * 512);
			short_by <= $urandom % len;
			req(32'(r), 64'h0, len, 32'h0, 0, 32'h0); exp_req(8'h00, 1, 3'h5);
			chk_reg(cs, 32'h00000012);
			chk_reg(cr, short_by);
		end
		short_by <= 32'h0;
		wb(1'b1, 8'h00, 32'h1C2);
		req(32'h01000000, 64'h0, 32'd512, 32'h0, 0, 32'h0); exp_req(8'h00, 1, 3'h1);
		req(32'h05000000, 64'h0, 32'h0, 32'h0, 0, 32'h0); exp_req(8'h00, 1, 3'h2);
		wb(1'b1, 8'h14, 32'h0);
		repeat (3) @(posedge clk);
		chk_reg(32'(cfg_seen), 32'h1);
		test_done();
	end
endmodule
`default_nettype wire
